//--- logic/ispf_pkg.sv
// Package: constants, types and register map of the flash programming block
package ispf_pkg;

  // Register bus shape
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;

  // Register offsets
  localparam logic [3:0] OFS_ADDR_HIGH = 4'h0;
  localparam logic [3:0] OFS_ADDR_LOW = 4'h1;
  localparam logic [3:0] OFS_READ_BYTE = 4'h2;
  localparam logic [3:0] OFS_WRITE_BYTE = 4'h3;
  localparam logic [3:0] OFS_PULSE_TIMING = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;

  // Reset values
  localparam logic [7:0] RST_ADDR_BYTE = 8'h00;
  // Table entry for a 7.5 MHz to 10 MHz primary oscillator
  localparam logic [7:0] RST_PULSE_TIMING = 8'h7b;
  // Bit 7 of the timing register is read only and reads zero
  localparam logic [7:0] TIMING_WR_MASK = 8'h7f;

  // Status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_BOOT_BIT = 3;

  // Address values with special meaning
  localparam logic [15:0] OPTION_ALIAS_ADDR = 16'hffff;
  localparam logic [15:0] OPTION_REAL_ADDR = 16'h1fff;
  localparam logic [15:0] MASS_ERASE_ADDR = 16'h0000;
  localparam logic [15:0] RESET_FETCH_ADDR = 16'h0000;

  // Boot ROM geometry: 1K bytes
  localparam int BOOT_ROM_BYTES = 1024;
  localparam int BOOT_ROM_AW = 10;

  // Primary oscillator cycles per unit of the timing value
  localparam int OSC_CYCLES_PER_UNIT = 32;

  // Operations issued through the hidden control port
  typedef enum logic [1:0] {
    ISPF_OP_READ = 2'b00,
    ISPF_OP_WRITE = 2'b01,
    ISPF_OP_PAGE_ERASE = 2'b10,
    ISPF_OP_MASS_ERASE = 2'b11
  } ispf_op_type;

  // Request presented to the flash array
  typedef struct packed {
    ispf_op_type op;
    logic [15:0] addr;
    logic [7:0] data;
  } ispf_flash_req_type;

endpackage : ispf_pkg

//--- logic/ispf_boot_rom.sv
// Boot ROM store with registered read data and a factory load port
`timescale 1ns/1ps
`default_nettype none

module ispf_boot_rom #(
  parameter int DEPTH = ispf_pkg::BOOT_ROM_BYTES,
  parameter int AW = ispf_pkg::BOOT_ROM_AW
) (
  // Clock
  input wire logic i_core_clk,
  // Factory load
  input wire logic i_load_we,
  input wire logic [AW-1:0] i_load_addr,
  input wire logic [7:0] i_load_data,
  // Fetch
  input wire logic i_rd,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);

  initial begin
    if (DEPTH != (1 << AW)) begin
      $error("ispf_boot_rom: DEPTH must equal 2**AW");
    end
  end

  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge i_core_clk) begin
    if (i_load_we) begin
      mem_r[i_load_addr] <= i_load_data;
    end
  end

  // Registered read keeps the fetch path a single flop deep
  always_ff @(posedge i_core_clk) begin
    if (i_rd) begin
      o_rd_data <= mem_r[i_rd_addr];
    end
  end

endmodule : ispf_boot_rom
`default_nettype wire

//--- logic/ispf_pulse_timer.sv
// Pulse width timer counting primary oscillator cycles
`timescale 1ns/1ps
`default_nettype none

module ispf_pulse_timer #(
  parameter int SCALE = ispf_pkg::OSC_CYCLES_PER_UNIT,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_start,
  input wire logic [7:0] i_units,
  input wire logic i_osc_tick,
  // Result
  output logic o_active,
  output logic o_done
);

  initial begin
    if (SCALE < 1 || (255 * SCALE) >= (1 << CW)) begin
      $error("ispf_pulse_timer: SCALE does not fit CW");
    end
  end

  logic [CW-1:0] left_r;
  logic [CW-1:0] load_val;
  logic last_tick;

  // Zero units still give one oscillator cycle of pulse
  assign load_val = (i_units == 8'h00) ? CW'(1) : CW'(i_units * SCALE);
  assign last_tick = o_active && i_osc_tick && (left_r == CW'(1));

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      left_r <= '0;
      o_active <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= last_tick;
      if (i_start && !o_active) begin
        left_r <= load_val;
        o_active <= 1'b1;
      end else if (last_tick) begin
        o_active <= 1'b0;
        left_r <= '0;
      end else if (o_active && i_osc_tick) begin
        left_r <= left_r - CW'(1);
      end
    end
  end

endmodule : ispf_pulse_timer
`default_nettype wire

//--- logic/ispf_flash_prog.sv
// In-system flash programming interface: registers, sequencer, boot select
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ispf_flash_prog #(
  parameter int OSC_SCALE = ispf_pkg::OSC_CYCLES_PER_UNIT,
  parameter int ROM_DEPTH = ispf_pkg::BOOT_ROM_BYTES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [ispf_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Hidden control port from the core sequencer
  input wire logic i_ctl_start,
  input wire ispf_pkg::ispf_op_type i_ctl_op,
  output logic o_ctl_busy,
  output logic o_ctl_done,
  // Flash array
  output ispf_pkg::ispf_flash_req_type o_flash_req,
  output logic o_flash_rd,
  output logic o_flash_pulse,
  input wire logic [7:0] i_flash_rdata,
  // Boot source and oscillator pins
  input wire logic i_boot_flex,
  input wire logic i_primary_oscillator_input,
  // Fetch start
  output logic o_run_from_boot,
  output logic [15:0] o_fetch_start_addr,
  // Boot ROM fetch and factory load
  input wire logic i_rom_rd,
  input wire logic [ispf_pkg::BOOT_ROM_AW-1:0] i_rom_addr,
  output logic [7:0] o_rom_data,
  input wire logic i_rom_load_we,
  input wire logic [ispf_pkg::BOOT_ROM_AW-1:0] i_rom_load_addr,
  input wire logic [7:0] i_rom_load_data
);

  initial begin
    if (ROM_DEPTH != ispf_pkg::BOOT_ROM_BYTES) begin
      $error("ispf_flash_prog: boot ROM must be 1K bytes");
    end
  end

  typedef enum logic [1:0] {
    ISPF_ST_IDLE = 2'b00,
    ISPF_ST_RD_ISSUE = 2'b01,
    ISPF_ST_RD_TAKE = 2'b10,
    ISPF_ST_PULSE = 2'b11
  } ispf_state_type;

  // Option byte alias decode, used by reads and by the request path
  function automatic logic [15:0] map_addr(input logic [15:0] a);
    map_addr = (a == ispf_pkg::OPTION_ALIAS_ADDR) ?
      ispf_pkg::OPTION_REAL_ADDR : a;
  endfunction : map_addr

  // Register state
  logic [7:0] addr_high_r;
  logic [7:0] addr_low_r;
  logic [7:0] read_byte_r;
  logic [7:0] write_byte_r;
  logic [7:0] timing_r;
  logic done_r;
  logic err_r;
  ispf_state_type state_r;
  ispf_state_type state_nxt;
  ispf_pkg::ispf_op_type op_r;

  // Pin synchronisers
  logic flex_meta_r;
  logic flex_sync_r;
  logic osc_meta_r;
  logic osc_sync_r;
  logic osc_prev_r;
  logic osc_tick;

  // Boot capture
  logic boot_cap_pend_r;
  logic [1:0] boot_wait_r;
  logic boot_sel_r;

  // Decodes
  logic wr_addr_high;
  logic wr_addr_low;
  logic wr_write_byte;
  logic wr_timing;
  logic wr_status;
  logic [15:0] full_addr;
  logic [15:0] flash_addr;
  logic [7:0] rd_mux;
  logic [7:0] status_val;
  logic start_ok;
  logic start_bad;
  logic pulse_op;
  logic mass_bad;
  logic rd_take;
  logic timer_active;
  logic timer_done;
  logic timer_start;
  logic op_finish;

  // Register port decode; the hidden control register has no offset
  assign wr_addr_high = i_reg_wr &&
    (i_reg_addr == ispf_pkg::OFS_ADDR_HIGH);
  assign wr_addr_low = i_reg_wr &&
    (i_reg_addr == ispf_pkg::OFS_ADDR_LOW);
  assign wr_write_byte = i_reg_wr &&
    (i_reg_addr == ispf_pkg::OFS_WRITE_BYTE);
  assign wr_timing = i_reg_wr &&
    (i_reg_addr == ispf_pkg::OFS_PULSE_TIMING);
  assign wr_status = i_reg_wr &&
    (i_reg_addr == ispf_pkg::OFS_STATUS);

  // Byte address from the two halves
  assign full_addr = {addr_high_r, addr_low_r};
  assign flash_addr = map_addr(full_addr);

  // Status word
  assign status_val = {4'h0, ~boot_sel_r, err_r, done_r,
    (state_r != ISPF_ST_IDLE)};

  // Read mux; unmapped and hidden offsets read zero
  assign rd_mux =
    (i_reg_addr == ispf_pkg::OFS_ADDR_HIGH) ? addr_high_r :
    (i_reg_addr == ispf_pkg::OFS_ADDR_LOW) ? addr_low_r :
    (i_reg_addr == ispf_pkg::OFS_READ_BYTE) ? read_byte_r :
    (i_reg_addr == ispf_pkg::OFS_WRITE_BYTE) ? write_byte_r :
    (i_reg_addr == ispf_pkg::OFS_PULSE_TIMING) ? timing_r :
    (i_reg_addr == ispf_pkg::OFS_STATUS) ? status_val :
    8'h00;

  // Command acceptance: only while idle, so pulses never overlap
  assign mass_bad = (i_ctl_op == ispf_pkg::ISPF_OP_MASS_ERASE) &&
    (full_addr != ispf_pkg::MASS_ERASE_ADDR);
  assign start_ok = i_ctl_start && (state_r == ISPF_ST_IDLE) &&
    !mass_bad;
  // Mass erase with a stray address is refused, not run
  assign start_bad = i_ctl_start && (state_r == ISPF_ST_IDLE) &&
    mass_bad;
  assign pulse_op = (i_ctl_op != ispf_pkg::ISPF_OP_READ);
  assign timer_start = start_ok && pulse_op;
  assign rd_take = (state_r == ISPF_ST_RD_TAKE);
  assign op_finish = rd_take ||
    ((state_r == ISPF_ST_PULSE) && timer_done);

  // Oscillator edge seen only past the second stage
  assign osc_tick = osc_sync_r && !osc_prev_r;

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ISPF_ST_IDLE: begin
        if (start_ok && pulse_op) begin
          state_nxt = ISPF_ST_PULSE;
        end else if (start_ok) begin
          state_nxt = ISPF_ST_RD_ISSUE;
        end
      end
      ISPF_ST_RD_ISSUE: begin
        state_nxt = ISPF_ST_RD_TAKE;
      end
      ISPF_ST_RD_TAKE: begin
        state_nxt = ISPF_ST_IDLE;
      end
      ISPF_ST_PULSE: begin
        if (timer_done) begin
          state_nxt = ISPF_ST_IDLE;
        end
      end
    endcase
  end

  // Pulse width timer
  ispf_pulse_timer #(
    .SCALE(OSC_SCALE),
    .CW(16)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_start(timer_start),
    .i_units(timing_r),
    .i_osc_tick(osc_tick),
    .o_active(timer_active),
    .o_done(timer_done)
  );

  // Boot ROM holding the resident programming routine
  ispf_boot_rom #(
    .DEPTH(ROM_DEPTH),
    .AW(ispf_pkg::BOOT_ROM_AW)
  ) u_rom (
    .i_core_clk(i_core_clk),
    .i_load_we(i_rom_load_we),
    .i_load_addr(i_rom_load_addr),
    .i_load_data(i_rom_load_data),
    .i_rd(i_rom_rd),
    .i_rd_addr(i_rom_addr),
    .o_rd_data(o_rom_data)
  );

  // Pin synchronisers
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      flex_meta_r <= 1'b0;
      flex_sync_r <= 1'b0;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      flex_meta_r <= i_boot_flex;
      flex_sync_r <= flex_meta_r;
      osc_meta_r <= i_primary_oscillator_input;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end

  // Boot source caught once the synchroniser has settled after release
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      boot_cap_pend_r <= 1'b1;
      boot_wait_r <= 2'd0;
      boot_sel_r <= 1'b0;
    end else if (boot_cap_pend_r) begin
      boot_wait_r <= boot_wait_r + 2'd1;
      if (boot_wait_r == 2'd2) begin
        boot_sel_r <= flex_sync_r;
        boot_cap_pend_r <= 1'b0;
      end
    end
  end

  // Fetch start: ROM if the synchronised flex input was low when caught after release, flash at zero otherwise
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_run_from_boot <= 1'b1;
      o_fetch_start_addr <= ispf_pkg::RESET_FETCH_ADDR;
    end else if (boot_cap_pend_r && boot_wait_r == 2'd2) begin
      o_run_from_boot <= !flex_sync_r;
      o_fetch_start_addr <= ispf_pkg::RESET_FETCH_ADDR;
    end
  end

  // Address registers
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      addr_high_r <= ispf_pkg::RST_ADDR_BYTE;
      addr_low_r <= ispf_pkg::RST_ADDR_BYTE;
    end else begin
      if (wr_addr_high) begin
        addr_high_r <= i_reg_wdata;
      end
      if (wr_addr_low) begin
        addr_low_r <= i_reg_wdata;
      end
    end
  end

  // Timing register; the top bit stays zero
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      timing_r <= ispf_pkg::RST_PULSE_TIMING;
    end else if (wr_timing) begin
      timing_r <= i_reg_wdata & ispf_pkg::TIMING_WR_MASK;
    end
  end

  // Data registers carry no reset; their content is undefined then
  always_ff @(posedge i_core_clk) begin
    if (wr_write_byte) begin
      write_byte_r <= i_reg_wdata;
    end
    if (rd_take) begin
      read_byte_r <= i_flash_rdata;
    end
  end

  // Sequencer and status flags; a new event wins over a clear
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state_r <= ISPF_ST_IDLE;
      op_r <= ispf_pkg::ISPF_OP_READ;
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start_ok) begin
        op_r <= i_ctl_op;
      end
      if (op_finish) begin
        done_r <= 1'b1;
      end else if (start_ok ||
                   (wr_status && i_reg_wdata[ispf_pkg::ST_DONE_BIT])) begin
        done_r <= 1'b0;
      end
      if (start_bad) begin
        err_r <= 1'b1;
      end else if (wr_status && i_reg_wdata[ispf_pkg::ST_ERR_BIT]) begin
        err_r <= 1'b0;
      end
    end
  end

  // Flash request address and data follow the live registers during a pulse;
  // software is expected to hold them steady meanwhile
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_flash_req <= '0;
      o_flash_rd <= 1'b0;
      o_flash_pulse <= 1'b0;
    end else begin
      o_flash_req.op <= start_ok ? i_ctl_op : op_r;
      o_flash_req.addr <= flash_addr;
      o_flash_req.data <= write_byte_r;
      o_flash_rd <= start_ok && !pulse_op;
      o_flash_pulse <= timer_start ||
        (timer_active && !timer_done);
    end
  end

  // Register read data and control handshake outputs
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
      o_ctl_busy <= 1'b0;
      o_ctl_done <= 1'b0;
    end else begin
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
      o_ctl_busy <= (state_nxt != ISPF_ST_IDLE);
      o_ctl_done <= op_finish;
    end
  end

endmodule : ispf_flash_prog
`default_nettype wire

//--- verification/ispf_flash_prog_monitor.sv
// Assertion checker for the flash programming block
`timescale 1ns/1ps
`default_nettype none

module ispf_flash_prog_monitor (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [ispf_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // Control port
  input wire logic i_ctl_start,
  input wire ispf_pkg::ispf_op_type i_ctl_op,
  input wire logic o_ctl_busy,
  input wire logic o_ctl_done,
  // Flash side and fetch start
  input wire ispf_pkg::ispf_flash_req_type o_flash_req,
  input wire logic o_flash_rd,
  input wire logic o_flash_pulse,
  input wire logic i_boot_flex,
  input wire logic o_run_from_boot,
  input wire logic [15:0] o_fetch_start_addr
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // A start only counts when the sequencer is idle
  sequence s_idle_start;
    i_ctl_start && !o_ctl_busy && !o_ctl_done;
  endsequence
  sequence s_read_walk;
    o_flash_rd && o_ctl_busy ##2 o_ctl_done && !o_ctl_busy;
  endsequence

  AST_READ_WALK: assert property (
    s_idle_start ##0 i_ctl_op == ispf_pkg::ISPF_OP_READ |=> s_read_walk)
    else $error("read sequence timing wrong");
  AST_WRITE_PULSE: assert property (
    s_idle_start ##0 i_ctl_op == ispf_pkg::ISPF_OP_WRITE |=>
    o_flash_pulse && o_flash_req.op == ispf_pkg::ISPF_OP_WRITE)
    else $error("write pulse not started");
  AST_PULSE_BUSY: assert property (o_flash_pulse |-> o_ctl_busy)
    else $error("pulse without busy");
  AST_PULSE_END: assert property ($fell(o_flash_pulse) |-> o_ctl_done)
    else $error("pulse end without done");
  AST_DONE_ONE: assert property (o_ctl_done |=> !o_ctl_done)
    else $error("done longer than one cycle");
  AST_ALIAS: assert property (
    o_flash_rd || o_flash_pulse |-> o_flash_req.addr != 16'hffff)
    else $error("alias address reached flash");
  AST_UNMAPPED: assert property (
    i_reg_rd && i_reg_addr > 4'h5 |=> o_reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  AST_FETCH: assert property (o_fetch_start_addr == 16'h0000)
    else $error("fetch start not zero");
  AST_BOOT: assert property (
    $rose(i_resetn) |-> ##3 o_run_from_boot == !i_boot_flex)
    else $error("boot source wrong");
  AST_RESET_OUT: assert property (
    $rose(i_resetn) |-> !o_ctl_busy && !o_flash_pulse && o_run_from_boot)
    else $error("outputs not at reset value");
endmodule : ispf_flash_prog_monitor

bind ispf_flash_prog ispf_flash_prog_monitor u_mon (.i_core_clk, .i_resetn,
  .i_reg_addr, .i_reg_rd, .o_reg_rdata, .i_ctl_start, .i_ctl_op,
  .o_ctl_busy, .o_ctl_done, .o_flash_req, .o_flash_rd, .o_flash_pulse,
  .i_boot_flex, .o_run_from_boot, .o_fetch_start_addr);

`default_nettype wire

//--- verification/ispf_flash_model.sv
// Flash array model answering reads, programs and erases
`timescale 1ns/1ps
`default_nettype none

module ispf_flash_model (
  // Clock
  input wire logic i_core_clk,
  // Requests
  input wire ispf_pkg::ispf_flash_req_type i_req,
  input wire logic i_rd,
  input wire logic i_pulse,
  // Read data
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic pulse_q = 1'b0;
  initial o_rdata = 8'h00;
  // Data valid only the cycle after a read; toggles otherwise
  always @(posedge i_core_clk) begin
    pulse_q <= i_pulse;
    if (i_rd) begin
      mem[i_req.addr] <= mem[i_req.addr];
      o_rdata <= mem[i_req.addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_pulse && i_req.op == ispf_pkg::ISPF_OP_WRITE) begin
      mem[i_req.addr] <= i_req.data;
    end
    // Page size unknown here: only the addressed byte is erased
    if (i_pulse && !pulse_q && i_req.op == ispf_pkg::ISPF_OP_PAGE_ERASE) begin
      mem[i_req.addr] <= 8'hff;
    end
    if (i_pulse && !pulse_q && i_req.op == ispf_pkg::ISPF_OP_MASS_ERASE) begin
      for (int i = 0; i < 65536; i++) begin
        mem[i] <= 8'hff;
      end
    end
  end
endmodule : ispf_flash_model

`default_nettype wire

//--- verification/tb_ispf_flash_prog.sv
// Testbench for the flash programming block
`timescale 1ns/1ps
`default_nettype none

module tb_ispf_flash_prog;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_ctl_start = 1'b0;
  ispf_pkg::ispf_op_type i_ctl_op = ispf_pkg::ISPF_OP_READ;
  logic i_boot_flex = 1'b0;
  logic osc = 1'b0;
  logic i_rom_rd = 1'b0;
  logic [9:0] i_rom_addr = 10'h000;
  logic i_rom_load_we = 1'b0;
  logic [9:0] i_rom_load_addr = 10'h000;
  logic [7:0] i_rom_load_data = 8'h00;
  logic [7:0] o_reg_rdata, i_flash_rdata, o_rom_data;
  logic o_ctl_busy, o_ctl_done, o_flash_rd, o_flash_pulse, o_run_from_boot;
  logic [15:0] o_fetch_start_addr;
  ispf_pkg::ispf_flash_req_type o_flash_req;
  int n_fail = 0;
  int checks = 0;
  int len;

  always #2.5 i_core_clk = ~i_core_clk;
  // Oscillator period chosen unrelated to the core clock
  always #21 osc = ~osc;

  ispf_flash_prog #(.OSC_SCALE(1)) u_dut (.i_core_clk, .i_resetn,
    .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_ctl_start, .i_ctl_op, .o_ctl_busy, .o_ctl_done, .o_flash_req,
    .o_flash_rd, .o_flash_pulse, .i_flash_rdata, .i_boot_flex,
    .i_primary_oscillator_input(osc), .o_run_from_boot,
    .o_fetch_start_addr, .i_rom_rd, .i_rom_addr, .o_rom_data,
    .i_rom_load_we, .i_rom_load_addr, .i_rom_load_data);

  ispf_flash_model u_flash (.i_core_clk, .i_req(o_flash_req),
    .i_rd(o_flash_rd), .i_pulse(o_flash_pulse), .o_rdata(i_flash_rdata));

  task automatic wrap_up();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] ad, input logic [7:0] m,
                        input logic [7:0] e);
    @(posedge i_core_clk);
    i_reg_addr <= ad;
    i_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk({8'h00, o_reg_rdata & m}, {8'h00, e});
  endtask : rd_chk

  task automatic set_addr(input logic [15:0] ad);
    wr_reg(ispf_pkg::OFS_ADDR_HIGH, ad[15:8]);
    wr_reg(ispf_pkg::OFS_ADDR_LOW, ad[7:0]);
  endtask : set_addr

  task automatic start_op(input ispf_pkg::ispf_op_type o);
    @(posedge i_core_clk);
    i_ctl_op <= o;
    i_ctl_start <= 1'b1;
    @(posedge i_core_clk);
    i_ctl_start <= 1'b0;
  endtask : start_op

  // Counts pulse cycles; a hang ends the run
  task automatic run_op(input ispf_pkg::ispf_op_type o);
    int k;
    len = 0;
    start_op(o);
    #1;
    for (k = 0; k < 4000 && o_ctl_done !== 1'b1; k++) begin
      if (o_flash_pulse === 1'b1) len++;
      @(posedge i_core_clk);
      #1;
    end
    if (k == 4000) begin
      n_fail++;
      wrap_up();
    end
  endtask : run_op

  task automatic do_reset(input logic f);
    @(posedge i_core_clk);
    i_boot_flex <= f;
    i_resetn <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    #1;
    chk({15'h0, o_run_from_boot}, {15'h0, ~f});
    chk(o_fetch_start_addr, ispf_pkg::RESET_FETCH_ADDR);
  endtask : do_reset

  initial begin
    do_reset(1'b0);
    rd_chk(ispf_pkg::OFS_STATUS, 8'h08, 8'h08);
    rd_chk(ispf_pkg::OFS_ADDR_HIGH, 8'hff, 8'h00);
    rd_chk(ispf_pkg::OFS_ADDR_LOW, 8'hff, 8'h00);
    rd_chk(ispf_pkg::OFS_PULSE_TIMING, 8'hff, 8'h7b);
    wr_reg(ispf_pkg::OFS_PULSE_TIMING, 8'hff);
    rd_chk(ispf_pkg::OFS_PULSE_TIMING, 8'hff, 8'h7f);
    wr_reg(4'h9, 8'h55);
    rd_chk(4'h9, 8'hff, 8'h00);
    // Small timing value keeps the pulse short
    wr_reg(ispf_pkg::OFS_PULSE_TIMING, 8'h03);
    set_addr(16'h0123);
    wr_reg(ispf_pkg::OFS_WRITE_BYTE, 8'h5a);
    rd_chk(ispf_pkg::OFS_ADDR_HIGH, 8'hff, 8'h01);
    rd_chk(ispf_pkg::OFS_ADDR_LOW, 8'hff, 8'h23);
    run_op(ispf_pkg::ISPF_OP_WRITE);
    chk({8'h00, u_flash.mem[16'h0123]}, 16'h005a);
    chk({15'h0, len >= 16 && len <= 34}, 16'h0001);
    rd_chk(ispf_pkg::OFS_STATUS, 8'h03, 8'h02);
    wr_reg(ispf_pkg::OFS_STATUS, 8'h02);
    rd_chk(ispf_pkg::OFS_STATUS, 8'h02, 8'h00);
    run_op(ispf_pkg::ISPF_OP_READ);
    rd_chk(ispf_pkg::OFS_READ_BYTE, 8'hff, 8'h5a);
    wr_reg(ispf_pkg::OFS_READ_BYTE, 8'h00);
    rd_chk(ispf_pkg::OFS_READ_BYTE, 8'hff, 8'h5a);
    u_flash.mem[16'h1fff] = 8'hc3;
    set_addr(16'hffff);
    run_op(ispf_pkg::ISPF_OP_READ);
    rd_chk(ispf_pkg::OFS_READ_BYTE, 8'hff, 8'hc3);
    set_addr(16'h0100);
    start_op(ispf_pkg::ISPF_OP_MASS_ERASE);
    repeat (4) @(posedge i_core_clk);
    rd_chk(ispf_pkg::OFS_STATUS, 8'h05, 8'h04);
    wr_reg(ispf_pkg::OFS_STATUS, 8'h04);
    rd_chk(ispf_pkg::OFS_STATUS, 8'h04, 8'h00);
    set_addr(16'h0000);
    run_op(ispf_pkg::ISPF_OP_MASS_ERASE);
    chk({8'h00, u_flash.mem[16'h0123]}, 16'h00ff);
    u_flash.mem[16'h0200] = 8'h11;
    set_addr(16'h0200);
    run_op(ispf_pkg::ISPF_OP_PAGE_ERASE);
    chk({8'h00, u_flash.mem[16'h0200]}, 16'h00ff);
    @(posedge i_core_clk);
    i_rom_load_we <= 1'b1;
    i_rom_load_addr <= 10'h3ff;
    i_rom_load_data <= 8'ha7;
    @(posedge i_core_clk);
    i_rom_load_we <= 1'b0;
    i_rom_addr <= 10'h3ff;
    i_rom_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rom_rd <= 1'b0;
    #1;
    chk({8'h00, o_rom_data}, 16'h00a7);
    do_reset(1'b1);
    rd_chk(ispf_pkg::OFS_STATUS, 8'h08, 8'h00);
    rd_chk(ispf_pkg::OFS_PULSE_TIMING, 8'hff, 8'h7b);
    wrap_up();
  end
endmodule : tb_ispf_flash_prog

`default_nettype wire
